// ==== core/fault_silo_cfg.svh ====
// constants for the fault status register and buffer readout path
// assumes a 50 MHz controller clock; included by bare name
`ifndef FAULT_SILO_CFG_SVH
`define FAULT_SILO_CFG_SVH
`define CLK_PERIOD_NS 20
`define CMD_TIMEOUT_MS 200
`define CMD_TIMEOUT_CYCLES ((`CMD_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define TIMER_W 24
`define WORD_W 12
`define BYTE_W 8
`define CODE_W 3
`define CODE_NONE 3'h0
`define CODE_DATA_LATE 3'h4
`define CODE_OP_INCOMPLETE 3'h2
`define CODE_HEADER_MISSING 3'h6
`define CODE_DATA_CRC 3'h1
`define CODE_HEADER_CRC 3'h3
`define FAULT_BIT_CRC 11
`define FAULT_BIT_OPI 10
`define FAULT_BIT_LATE 9
`define FAULT_BIT_DRIVE 1
`define FAULT_BIT_READY 0
`define ZERO_WORD 12'h000
`define HDR_BYTES 3'h6
`define HDR_ZERO_LO 3'h2
`define HDR_ZERO_HI 3'h3
`define BUF_DEPTH 2
`endif

// ==== core/fault_silo_pkg.sv ====
// types shared by the fault status and buffer readout files
// assumes fault_silo_cfg.svh constants are available
`include "fault_silo_cfg.svh"
package fault_silo_pkg;
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_SEARCH,
    OP_TRANSFER
  } op_state_t;
  typedef struct packed {
    logic [`WORD_W-1:0] data;
  } silo_word_t;
endpackage

// ==== core/silo_buffer.sv ====
// two-entry valid/ready buffer on the buffer data path
// assumes a single clock; flush drops both entries
`timescale 1ns/1ns
`include "fault_silo_cfg.svh"
module silo_buffer (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  input fault_silo_pkg::silo_word_t in_word_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output fault_silo_pkg::silo_word_t out_word_out,
  input wire logic out_ready_in,
  // occupancy
  output logic full_out,
  output logic empty_out
);
  fault_silo_pkg::silo_word_t mem_q [`BUF_DEPTH];
  logic rd_q;
  logic wr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign push = in_valid_in && (count_q != 2'h2);
  assign pop = out_ready_in && (count_q != 2'h0);
  assign in_ready_out = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign out_word_out = mem_q[rd_q];
  assign full_out = (count_q == 2'h2);
  assign empty_out = (count_q == 2'h0);

  // storage written only on push, so no reset needed for data
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_q[wr_q] <= in_word_in;
    end
  end

  // pointers and count
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (flush_in) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== core/fault_silo.sv ====
// fault status register and buffer readout path of the cartridge controller
// assumes command sequencing outside supplies op start/end, crc and drive events
`timescale 1ns/1ns
`include "fault_silo_cfg.svh"
module fault_silo #(
  // command timeout in clock cycles; a bench may shorten it to reach the timeout paths
  parameter int timeout_cycles = `CMD_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // processor instructions
  input wire logic fault_read_iot_in,
  input wire logic buffer_read_iot_in,
  input wire logic cmd_b_load_in,
  input wire logic ctrl_init_in,
  // command progress
  input wire logic op_start_in,
  input wire logic op_done_in,
  input wire logic op_is_write_in,
  input wire logic op_is_read_in,
  input wire logic sector_found_in,
  input wire logic word_count_zero_in,
  input wire logic checksum_mismatch_in,
  input wire logic header_phase_in,
  // drive side
  input wire logic drive_fault_line_in,
  input wire logic drive_idle_in,
  input wire logic seek_start_in,
  input wire logic seek_done_in,
  input wire logic status_valid_in,
  input wire logic [`WORD_W-1:0] status_word1_in,
  input wire logic [`WORD_W-1:0] status_word2_in,
  input wire logic hdr_byte_valid_in,
  input wire logic [`BYTE_W-1:0] hdr_byte_in,
  // data words from disk while reading
  input wire logic read_word_valid_in,
  input wire logic [`WORD_W-1:0] read_word_in,
  // processor working register
  output logic [`WORD_W-1:0] cpu_work_register_out,
  output logic cpu_work_valid_out,
  output logic buffer_full_out
);
  fault_silo_pkg::op_state_t state_q;
  logic [`TIMER_W-1:0] timer_q;
  logic [`CODE_W-1:0] code_q;
  logic ready_q;
  logic drive_fault_q;
  logic timeout;
  logic late_write;
  logic late_read;
  logic status_pend_q;
  logic [`WORD_W-1:0] status2_q;
  logic [2:0] hdr_idx_q;
  logic in_valid;
  fault_silo_pkg::silo_word_t in_word;
  logic in_ready;
  logic out_valid;
  fault_silo_pkg::silo_word_t out_word;
  logic buf_full;
  logic buf_empty;

  // widen a received byte into a buffer word
  function automatic logic [`WORD_W-1:0] byte_to_word(input logic [`BYTE_W-1:0] b);
    byte_to_word = {{(`WORD_W-`BYTE_W){1'b0}}, b};
  endfunction

  assign timeout = (timer_q == `TIMER_W'(timeout_cycles - 1));
  assign late_write = (state_q == fault_silo_pkg::OP_TRANSFER) && op_is_write_in
                      && buf_empty && !word_count_zero_in;
  assign late_read = (state_q == fault_silo_pkg::OP_TRANSFER) && op_is_read_in
                     && buf_full && read_word_valid_in && !word_count_zero_in;

  // command progress: search for the sector, then transfer
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= fault_silo_pkg::OP_IDLE;
    end else if (ctrl_init_in || op_done_in || timeout) begin
      state_q <= fault_silo_pkg::OP_IDLE;
    end else begin
      case (state_q)
        fault_silo_pkg::OP_IDLE: begin
          if (op_start_in) begin
            state_q <= fault_silo_pkg::OP_SEARCH;
          end
        end
        fault_silo_pkg::OP_SEARCH: begin
          if (sector_found_in) begin
            state_q <= fault_silo_pkg::OP_TRANSFER;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // timer measured from the command start, stops with the command
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_q <= '0;
    end else if (op_start_in || state_q == fault_silo_pkg::OP_IDLE) begin
      timer_q <= '0;
    end else if (!timeout) begin
      timer_q <= timer_q + `TIMER_W'(1);
    end
  end

  // error code; a new error in the clearing cycle wins over the clear
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      code_q <= `CODE_NONE;
    end else if (timeout && state_q == fault_silo_pkg::OP_SEARCH) begin
      code_q <= `CODE_HEADER_MISSING;
    end else if (timeout && state_q == fault_silo_pkg::OP_TRANSFER) begin
      code_q <= `CODE_OP_INCOMPLETE;
    end else if (checksum_mismatch_in && state_q != fault_silo_pkg::OP_IDLE) begin
      code_q <= header_phase_in ? `CODE_HEADER_CRC : `CODE_DATA_CRC;
    end else if (late_write || late_read) begin
      code_q <= `CODE_DATA_LATE;
    end else if (ctrl_init_in || cmd_b_load_in) begin
      code_q <= `CODE_NONE;
    end
  end

  // drive fault is a registered copy of the line, ready copies drive idle unless seek start clears or seek done sets it
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_fault_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      drive_fault_q <= drive_fault_line_in;
      if (seek_start_in) begin
        ready_q <= 1'b0;
      end else if (seek_done_in) begin
        ready_q <= 1'b1;
      end else begin
        ready_q <= drive_idle_in;
      end
    end
  end

  // fill the buffer: status pair, header bytes or read data
  always_comb begin
    in_valid = 1'b0;
    in_word.data = `ZERO_WORD;
    if (status_valid_in) begin
      in_valid = 1'b1;
      in_word.data = status_word1_in;
    end else if (status_pend_q) begin
      in_valid = 1'b1;
      in_word.data = status2_q;
    end else if (hdr_byte_valid_in) begin
      in_valid = 1'b1;
      // third and fourth header bytes land as zero words, so six bytes give six words
      if (hdr_idx_q == `HDR_ZERO_LO || hdr_idx_q == `HDR_ZERO_HI) begin
        in_word.data = `ZERO_WORD;
      end else begin
        in_word.data = byte_to_word(hdr_byte_in);
      end
    end else if (read_word_valid_in) begin
      in_valid = 1'b1;
      in_word.data = read_word_in;
    end
  end

  // second status word is held from the cycle after the first until the buffer has room
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_pend_q <= 1'b0;
      status2_q <= `ZERO_WORD;
    end else if (ctrl_init_in) begin
      status_pend_q <= 1'b0;
    end else if (status_valid_in) begin
      status_pend_q <= 1'b1;
      status2_q <= status_word2_in;
    end else if (status_pend_q && in_ready) begin
      status_pend_q <= 1'b0;
    end
  end

  // header byte position; a byte lost to a full buffer does not move it
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hdr_idx_q <= 3'h0;
    end else if (ctrl_init_in || op_start_in) begin
      hdr_idx_q <= 3'h0;
    end else if (in_ready && hdr_byte_valid_in && !status_valid_in && !status_pend_q
                 && hdr_idx_q != `HDR_BYTES) begin
      hdr_idx_q <= hdr_idx_q + 3'h1;
    end
  end

  silo_buffer u_buf (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .flush_in(ctrl_init_in),
    .in_valid_in(in_valid),
    .in_word_in(in_word),
    .in_ready_out(in_ready),
    .out_valid_out(out_valid),
    .out_word_out(out_word),
    .out_ready_in(buffer_read_iot_in),
    .full_out(buf_full),
    .empty_out(buf_empty)
  );

  // working register: fault status or buffer head word
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_work_register_out <= `ZERO_WORD;
      cpu_work_valid_out <= 1'b0;
      buffer_full_out <= 1'b0;
    end else begin
      buffer_full_out <= buf_full;
      cpu_work_valid_out <= fault_read_iot_in || buffer_read_iot_in;
      if (fault_read_iot_in) begin
        cpu_work_register_out <= `ZERO_WORD;
        cpu_work_register_out[`FAULT_BIT_CRC] <= code_q[0];
        cpu_work_register_out[`FAULT_BIT_OPI] <= code_q[1];
        cpu_work_register_out[`FAULT_BIT_LATE] <= code_q[2];
        cpu_work_register_out[`FAULT_BIT_DRIVE] <= drive_fault_q;
        cpu_work_register_out[`FAULT_BIT_READY] <= ready_q;
      end else if (buffer_read_iot_in) begin
        cpu_work_register_out <= out_valid ? out_word.data : `ZERO_WORD;
      end
    end
  end
endmodule

// ==== tb/fault_silo_assertions.sv ====
// concurrent checks on the fault_silo ports
// assumes one clock domain; bound to every fault_silo instance
`timescale 1ns/1ns
module fault_silo_assertions (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // instructions and events
  input wire logic fault_read_iot_in,
  input wire logic buffer_read_iot_in,
  input wire logic cmd_b_load_in,
  input wire logic ctrl_init_in,
  input wire logic op_is_write_in,
  input wire logic op_is_read_in,
  input wire logic word_count_zero_in,
  input wire logic checksum_mismatch_in,
  input wire logic header_phase_in,
  input wire logic drive_fault_line_in,
  input wire logic drive_idle_in,
  input wire logic status_valid_in,
  input wire logic hdr_byte_valid_in,
  input wire logic read_word_valid_in,
  // answers
  input wire logic [11:0] cpu_work_register_out,
  input wire logic cpu_work_valid_out,
  input wire logic buffer_full_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // helper terms; quiet also keeps level-driven late faults out of the clear check
  wire iot = fault_read_iot_in || buffer_read_iot_in;
  wire nofill = !status_valid_in && !hdr_byte_valid_in && !read_word_valid_in;
  wire calm = !cmd_b_load_in && !ctrl_init_in;
  wire quiet = calm && !checksum_mismatch_in && !op_is_write_in && !op_is_read_in;
  chk_answer_follows: assert property (iot |=> cpu_work_valid_out)
    else $error("no answer after instruction");
  chk_word_stands: assert property (!cpu_work_valid_out |-> $stable(cpu_work_register_out))
    else $error("working word moved without answer");
  chk_fault_follows: assert property ((fault_read_iot_in && $stable(drive_fault_line_in)) |=>
    cpu_work_register_out[1] == $past(drive_fault_line_in)) else $error("drive fault bit wrong");
  chk_busy_not_ready: assert property ((fault_read_iot_in && !drive_idle_in &&
    !$past(drive_idle_in)) |=> !cpu_work_register_out[0]) else $error("ready while busy");
  chk_empty_after_init: assert property (ctrl_init_in ##1 nofill[*3] ##1
    (buffer_read_iot_in && !fault_read_iot_in && nofill) |=> cpu_work_register_out == 12'h000)
    else $error("flushed buffer gave data");
  chk_crc_reported: assert property ((checksum_mismatch_in && !header_phase_in) ##1
    calm[*2] ##1 fault_read_iot_in |=> cpu_work_register_out[11]) else $error("crc not seen");
  chk_late_on_full: assert property ((op_is_read_in && buffer_full_out && read_word_valid_in &&
    !word_count_zero_in) ##1 calm[*2] ##1 fault_read_iot_in |=> cpu_work_register_out[11:9] != 3'h0)
    else $error("lost word not flagged");
  chk_code_cleared: assert property (cmd_b_load_in ##1 quiet[*2] ##1
    (fault_read_iot_in && quiet) |=> cpu_work_register_out[11:9] == 3'h0)
    else $error("code survived command load");
endmodule
bind fault_silo fault_silo_assertions chk (.*);

// ==== tb/cpu_model.sv ====
// processor model issuing the two read instructions
// assumes the answer arrives one cycle after the instruction edge
`timescale 1ns/1ns
module cpu_model (
  // clock
  input wire logic clock_in,
  // instructions
  output logic fault_read_iot_out,
  output logic buffer_read_iot_out,
  // answer
  input wire logic [11:0] cpu_work_register_in,
  input wire logic cpu_work_valid_in
);
  initial begin
    fault_read_iot_out = 1'b0;
    buffer_read_iot_out = 1'b0;
  end
  // one instruction held for one edge; the answer is taken once it has settled
  task automatic iot(input logic sel, output logic [11:0] word, output logic seen);
    fault_read_iot_out = !sel;
    buffer_read_iot_out = sel;
    @(posedge clock_in);
    #2;
    fault_read_iot_out = 1'b0;
    buffer_read_iot_out = 1'b0;
    word = cpu_work_register_in;
    seen = cpu_work_valid_in;
    // one quiet edge, so a following instruction never lowers and raises a strobe at once
    @(posedge clock_in);
    #2;
  endtask
endmodule

// ==== tb/fault_silo_tb.sv ====
// self-checking bench for fault_silo with a processor model
// assumes answers one cycle after an instruction edge
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module fault_silo_tb;
  // stimulus, quiet at time zero
  logic clock_in = 1'b0, reset_n_in = 1'b0, cmd_b_load_in = 1'b0, ctrl_init_in = 1'b0;
  logic op_start_in = 1'b0, op_done_in = 1'b0, op_is_write_in = 1'b0, op_is_read_in = 1'b0;
  logic sector_found_in = 1'b0, word_count_zero_in = 1'b0, checksum_mismatch_in = 1'b0;
  logic header_phase_in = 1'b0, drive_fault_line_in = 1'b0, drive_idle_in = 1'b1;
  logic seek_start_in = 1'b0, seek_done_in = 1'b0, status_valid_in = 1'b0;
  logic hdr_byte_valid_in = 1'b0, read_word_valid_in = 1'b0;
  logic [11:0] status_word1_in = 12'h000, status_word2_in = 12'h000, read_word_in = 12'h000;
  logic [7:0] hdr_byte_in = 8'h00;
  // outputs
  logic fault_read_iot_in, buffer_read_iot_in, cpu_work_valid_out, buffer_full_out;
  logic [11:0] cpu_work_register_out;
  int mismatches = 0, checks = 0;
  localparam logic [11:0] fmask = 12'hE03, wmask = 12'hFFF;
  localparam int short_timeout = 100; // command timeout in cycles, shortened for the bench
  always #10 clock_in = ~clock_in;
  fault_silo #(.timeout_cycles(short_timeout)) DUT (.*);
  cpu_model cpu (.clock_in(clock_in), .fault_read_iot_out(fault_read_iot_in),
    .buffer_read_iot_out(buffer_read_iot_in), .cpu_work_register_in(cpu_work_register_out),
    .cpu_work_valid_in(cpu_work_valid_out));
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  // a gap cycle after each pulse so no signal is written twice in one step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask
  // fault word: code in ac0..ac2 order on bits 11:9, drive bits at the bottom
  function automatic logic [11:0] fw(input logic [2:0] c, input logic de, input logic rdy);
    return {c, 7'h00, de, rdy};
  endfunction
  task automatic rd(input logic b, input logic [11:0] e, input logic [11:0] m);
    logic [11:0] w;
    logic v;
    cpu.iot(b, w, v);
    `CHK("valid", 1'b1, v)
    `CHK("word", e, w & m)
  endtask
  task finish_test;
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_drive;
    drive_fault_line_in = 1'b1;
    step(2);
    rd(1'b0, fw(3'h0, 1'b1, 1'b1), fmask);
    drive_fault_line_in = 1'b0;
    drive_idle_in = 1'b0;
    pulse(seek_start_in);
    rd(1'b0, fw(3'h0, 1'b0, 1'b0), fmask);
    drive_idle_in = 1'b1;
    pulse(seek_done_in);
    step(1);
    rd(1'b0, fw(3'h0, 1'b0, 1'b1), fmask);
  endtask
  // late, data crc, header crc, each after a fresh load
  task automatic t_codes;
    logic [2:0] codes [3] = '{3'h1, 3'h4, 3'h6};
    for (int k = 0; k < 3; k++) begin
      pulse(cmd_b_load_in);
      op_is_write_in = (k == 0);
      header_phase_in = (k == 2);
      pulse(op_start_in);
      pulse(sector_found_in);
      if (k != 0) pulse(checksum_mismatch_in);
      else step(2);
      step(1);
      rd(1'b0, fw(codes[k], 1'b0, 1'b1), fmask);
      op_is_write_in = 1'b0;
      header_phase_in = 1'b0;
      pulse(op_done_in);
    end
    pulse(cmd_b_load_in);
    step(1);
    rd(1'b0, fw(3'h0, 1'b0, 1'b1), fmask);
  endtask
  task automatic t_status;
    status_word1_in = 12'hA5C;
    status_word2_in = 12'h3B1;
    pulse(status_valid_in);
    step(1);
    `CHK("full", 1'b1, buffer_full_out)
    rd(1'b1, 12'hA5C, wmask);
    rd(1'b1, 12'h3B1, wmask);
    rd(1'b1, 12'h000, wmask);
  endtask
  // software sets byte mode before this command
  task automatic t_header;
    pulse(op_start_in);
    for (int i = 0; i < 6; i++) begin
      hdr_byte_in = 8'hC1 + 8'(8'h11 * i);
      pulse(hdr_byte_valid_in);
      if (i % 2 == 1) begin
        for (int j = i - 1; j <= i; j++) begin
          rd(1'b1, (j / 2 == 1) ? 12'h000 : {4'h0, 8'hC1 + 8'(8'h11 * j)}, wmask);
        end
      end
    end
    pulse(op_done_in);
  endtask
  // two words offered to a full buffer are lost and flagged; init then clears all
  task automatic t_late;
    pulse(cmd_b_load_in);
    op_is_read_in = 1'b1;
    pulse(op_start_in);
    pulse(sector_found_in);
    for (int i = 1; i <= 4; i++) begin
      read_word_in = 12'(12'h101 * i);
      pulse(read_word_valid_in);
    end
    `CHK("full", 1'b1, buffer_full_out)
    step(1);
    rd(1'b0, fw(3'h1, 1'b0, 1'b1), fmask);
    rd(1'b1, 12'h101, wmask);
    op_is_read_in = 1'b0;
    pulse(op_done_in);
    pulse(ctrl_init_in);
    rd(1'b0, fw(3'h0, 1'b0, 1'b1), fmask);
    rd(1'b1, 12'h000, wmask);
  endtask
  // commands left running: search ends as header missing, transfer as incomplete
  task automatic t_timeout;
    pulse(cmd_b_load_in);
    pulse(op_start_in);
    step(short_timeout);
    rd(1'b0, fw(3'h3, 1'b0, 1'b1), fmask);
    pulse(cmd_b_load_in);
    pulse(op_start_in);
    pulse(sector_found_in);
    step(short_timeout);
    rd(1'b0, fw(3'h2, 1'b0, 1'b1), fmask);
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    #2;
    reset_n_in = 1'b1;
    step(1);
    t_drive();
    t_codes();
    t_status();
    t_header();
    t_late();
    t_timeout();
    finish_test();
  end
  // hang guard
  initial begin
    #1000000;
    mismatches++;
    finish_test();
  end
endmodule
